// ### rtl/pos_pkg.sv
// Purpose: Constants and types for the programmable output controller
// Assumes: 25 MHz clk, times counted in 100 ms ticks
// Notes:
// Functional notes
// - Output type holds seven encodings, general control up to interlocking.
// - Output type resets to zero, a general control output.
// - Type five ignores collective disable and never lights an indicator.
// - Control, ventilation, extinguishing, interlocking off by type disable.
// - Alarm devices off by disable or silence; fault blinks, disable steady.
// - Active ventilation output, or its feedback, lights ventilation indicator.
// - Active extinguishing output, or its feedback, lights its indicator.
// - Routing output disabled with routing relay; lights routing indicator.
// - Active interlocking output is reported in the interlocking status view.
// - Polarity selects idle level; drive inverts while output is active.
// - Supervision on by default, off when software clears supervised.
// - Idle-high output is never supervised.
// - Idle-high output driven low for seconds during restart.
// - Period is steady, fixed 0.8/0.8 intermittent, or user period 1-8.
// - User period type encodings zero to six, including delayed forms.
// - User period holds delay, pulse length, pulse off, de-activation times.
// - Fixed-blink-only units allow only the 0.8s/0.8s intermittent pattern.
// - Limited-timing units clamp on, off and pulse times to 5.6s.
// - Interlocking outputs accept only steady and steady delayed activation.
// - Output requested active while control expression is true and the output is not forced off.
`default_nettype none
package pos_pkg;
  // Register offsets
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [1:0] OFS_PER_PAGE = 2'b01;
  // Configuration fields
  localparam int CFG_TYPE_LSB = 0;
  localparam int CFG_POL_BIT = 3;
  localparam int CFG_SUP_BIT = 4;
  localparam int CFG_SEL_LSB = 5;
  localparam int CFG_UNIT_LSB = 9;
  localparam int CFG_FB_BIT = 11;
  localparam logic [11:0] CFG_RST = 12'h010;
  localparam logic [6:0] CMD_RST = 7'h00;
  // Period time fields inside a time word
  localparam int TM_DELAY_LSB = 0;
  localparam int TM_PLEN_LSB = 8;
  localparam int TM_POFF_LSB = 16;
  localparam int TM_DEACT_LSB = 24;
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_NS = 100_000_000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int RESTART_LOW_MS = 3000;
  // Divide first: the plain product would overflow a 32-bit int
  localparam int RESTART_CYCLES = RESTART_LOW_MS * (1_000_000 / CLK_PERIOD_NS);
  localparam logic [7:0] FIXED_BLINK_TICKS = 8'h08;
  localparam logic [7:0] LIMIT_TICKS = 8'h38;

  typedef enum logic [2:0] {
    OT_CONTROL = 3'h0, OT_VENT = 3'h1, OT_EXTING = 3'h2, OT_ALARM = 3'h3,
    OT_ROUTING = 3'h4, OT_NEUTRAL = 3'h5, OT_INTERLOCK = 3'h6
  } pos_otype_t;
  typedef enum logic [2:0] {
    PT_STEADY = 3'h0, PT_INTERM = 3'h1, PT_PULSE = 3'h2, PT_STEADY_DA = 3'h3,
    PT_INTERM_DA = 3'h4, PT_PULSE_DA = 3'h5, PT_STEADY_DD = 3'h6
  } pos_ptype_t;
  typedef enum logic [1:0] {
    UC_FULL = 2'h0, UC_FIXED_BLINK = 2'h1, UC_LIMITED = 2'h2
  } pos_unit_t;
  typedef enum logic [2:0] {
    GS_IDLE = 3'b000, GS_DELAY = 3'b001, GS_ON = 3'b011, GS_OFF = 3'b010,
    GS_DONE = 3'b110, GS_HOLD = 3'b111
  } pos_gstate_t;
endpackage
`default_nettype wire

// ### rtl/pos_output.sv
// Purpose: One programmable output: type gating, polarity, supervision,
//   indicators and signal-period generator
// Assumes: single 25 MHz clock, pin inputs synchronised here
// Notes: times in 100 ms ticks; register reads answer one cycle later
//
// The implementer's own choices: the plain strobed port and the register addresses.
`default_nettype none
module pos_output
  import pos_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES,
  parameter int RESTART_LEN = RESTART_CYCLES,
  parameter int NUM_USER = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // Control request from expression logic
  input wire logic ctrlExpr,
  // Pins
  input wire logic silencePin,
  input wire logic feedbackPin,
  input wire logic outFaultPin,
  // Output drive and status
  output logic outDrive,
  output logic supervisionOn,
  output logic interlockView,
  // Indicators
  output logic ledVent,
  output logic ledExting,
  output logic ledRouting,
  output logic ledAlarmFaultDis,
  output logic ledRoutingFaultDis
);
  logic [11:0] cfg_reg;
  logic [6:0] cmd_reg;
  logic [2:0] perType_reg [NUM_USER];
  logic [31:0] perTime_reg [NUM_USER];
  logic [2:0] syncA_reg, syncB_reg;
  logic [31:0] rdata_reg, rdata_next;
  logic [21:0] tickCnt_reg;
  logic tick;
  logic [7:0] tCnt_reg;
  logic [2:0] blinkCnt_reg;
  logic [26:0] rstCnt_reg;
  logic restartLow;
  pos_gstate_t gs_reg, gs_next;

  // Pin synchronisers: the first stage feeds only the second
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      syncA_reg <= 3'h0;
      syncB_reg <= 3'h0;
    end else begin
      syncA_reg <= {outFaultPin, feedbackPin, silencePin};
      syncB_reg <= syncA_reg;
    end
  end
  wire silenceSync = syncB_reg[0];
  wire feedbackSync = syncB_reg[1];
  wire faultSync = syncB_reg[2];

  // Field decode
  // type field
  wire [2:0] oType = cfg_reg[CFG_TYPE_LSB +: 3];
  wire polHigh = cfg_reg[CFG_POL_BIT];
  wire supSet = cfg_reg[CFG_SUP_BIT];
  wire [3:0] perSel = cfg_reg[CFG_SEL_LSB +: 4];
  wire [1:0] unitCls = cfg_reg[CFG_UNIT_LSB +: 2];
  wire useFeedback = cfg_reg[CFG_FB_BIT];

  // Bus decode
  wire perPage = regAddr[7:6] == OFS_PER_PAGE;
  wire [2:0] perIdx = regAddr[5:3];
  wire hitCfg = regAddr == OFS_CFG;
  wire hitCmd = regAddr == OFS_CMD;
  wire hitStat = regAddr == OFS_STAT;
  wire hitPType = perPage && regAddr[2:0] == 3'h0;
  wire hitPTime = perPage && regAddr[2:0] == 3'h4;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_reg <= CFG_RST;
      cmd_reg <= CMD_RST;
    end else if (regWr && hitCfg) begin
      cfg_reg <= regWdata[11:0];
    end else if (regWr && hitCmd) begin
      cmd_reg <= regWdata[6:0];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_USER; gi++) begin : g_per
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          perType_reg[gi] <= 3'h0;
          perTime_reg[gi] <= 32'h0000_0000;
        end else if (regWr && hitPType && perIdx == 3'(gi)) begin
          perType_reg[gi] <= regWdata[2:0];
        end else if (regWr && hitPTime && perIdx == 3'(gi)) begin
          perTime_reg[gi] <= regWdata;
        end
      end
    end
  endgenerate

  // 100 ms tick and restart hold counter
  wire tickWrap = tickCnt_reg == 22'(TICK_LEN - 1);
  assign tick = tickWrap;
  assign restartLow = rstCnt_reg != 27'(RESTART_LEN);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tickCnt_reg <= 22'h0;
      blinkCnt_reg <= 3'h0;
      rstCnt_reg <= 27'h0;
    end else begin
      tickCnt_reg <= tickWrap ? 22'h0 : tickCnt_reg + 22'h1;
      if (tick) blinkCnt_reg <= blinkCnt_reg + 3'h1;
      if (restartLow) rstCnt_reg <= rstCnt_reg + 27'h1;
    end
  end
  wire blinkPhase = blinkCnt_reg[2];

  wire isUser = perSel >= 4'h2 && perSel <= 4'h9;
  wire [2:0] uIdx = 3'(perSel - 4'h2);
  wire [2:0] rawType = isUser ? perType_reg[uIdx] :
                       (perSel == 4'h1 ? PT_INTERM : PT_STEADY);
  wire [31:0] rawTime = isUser ? perTime_reg[uIdx] :
                        {8'h00, FIXED_BLINK_TICKS, FIXED_BLINK_TICKS, 8'h00};
  wire ilOk = rawType == PT_STEADY || rawType == PT_STEADY_DA;
  wire [2:0] pType = (oType == OT_INTERLOCK && !ilOk) ? PT_STEADY :
                     (rawType > PT_STEADY_DD ? PT_STEADY : rawType);
  wire [7:0] tDelay = rawTime[TM_DELAY_LSB +: 8];
  wire [7:0] tDeact = rawTime[TM_DEACT_LSB +: 8];
  wire [7:0] uPlen = rawTime[TM_PLEN_LSB +: 8];
  wire [7:0] uPoff = rawTime[TM_POFF_LSB +: 8];
  wire limited = unitCls == UC_LIMITED;
  wire fixedBlink = unitCls == UC_FIXED_BLINK;
  wire [7:0] cPlen = (limited && uPlen > LIMIT_TICKS) ? LIMIT_TICKS : uPlen;
  wire [7:0] cPoff = (limited && uPoff > LIMIT_TICKS) ? LIMIT_TICKS : uPoff;
  wire isInterm = pType == PT_INTERM || pType == PT_INTERM_DA;
  wire [7:0] tPlen = (fixedBlink && isInterm) ? FIXED_BLINK_TICKS : cPlen;
  wire [7:0] tPoff = (fixedBlink && isInterm) ? FIXED_BLINK_TICKS : cPoff;
  wire isPulse = pType == PT_PULSE || pType == PT_PULSE_DA;
  wire delayAct = pType == PT_STEADY_DA || pType == PT_INTERM_DA ||
                  pType == PT_PULSE_DA;

  // Disablement gating
  wire typeColl = oType == OT_CONTROL || oType == OT_VENT ||
                  oType == OT_EXTING || oType == OT_INTERLOCK;
  wire collOff = typeColl && cmd_reg[oType];
  wire alarmDis = oType == OT_ALARM && (cmd_reg[OT_ALARM] || silenceSync);
  wire routDis = oType == OT_ROUTING && cmd_reg[OT_ROUTING];
  wire forcedOff = oType != OT_NEUTRAL && (collOff || alarmDis || routDis);
  wire req = ctrlExpr && !forcedOff;

  // Period generator
  wire [7:0] curLimit = gs_reg == GS_DELAY ? tDelay :
                        gs_reg == GS_ON ? tPlen :
                        gs_reg == GS_OFF ? tPoff : tDeact;
  wire timeUp = tCnt_reg >= curLimit;
  always_comb begin
    gs_next = gs_reg;
    case (gs_reg)
      GS_IDLE: if (req) gs_next = delayAct ? GS_DELAY : GS_ON;
      GS_DELAY: begin
        if (!req) gs_next = GS_IDLE;
        else if (timeUp) gs_next = GS_ON;
      end
      GS_ON: begin
        if (forcedOff) gs_next = GS_IDLE;
        else if (!req) gs_next = pType == PT_STEADY_DD ? GS_HOLD : GS_IDLE;
        else if (isPulse && timeUp) gs_next = GS_DONE;
        else if (isInterm && timeUp) gs_next = GS_OFF;
      end
      GS_OFF: begin
        if (!req) gs_next = GS_IDLE;
        else if (timeUp) gs_next = GS_ON;
      end
      GS_DONE: if (!req) gs_next = GS_IDLE;
      GS_HOLD: begin
        if (forcedOff) gs_next = GS_IDLE;
        else if (ctrlExpr) gs_next = GS_ON;
        else if (timeUp) gs_next = GS_IDLE;
      end
      default: gs_next = GS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gs_reg <= GS_IDLE;
      tCnt_reg <= 8'h00;
    end else begin
      gs_reg <= gs_next;
      if (gs_next != gs_reg) tCnt_reg <= 8'h00;
      else if (tick && tCnt_reg != 8'hFF) tCnt_reg <= tCnt_reg + 8'h01;
    end
  end

  wire active = gs_reg == GS_ON || gs_reg == GS_HOLD;

  // Output drive and indicators are registered to keep pins glitch free
  logic [7:0] outs_reg, outs_next;
  always_comb begin
    outs_next = 8'h00;
    outs_next[0] = !restartLow && (polHigh ^ active);
    outs_next[1] = supSet && !polHigh;
    outs_next[2] = oType == OT_INTERLOCK && active;
    outs_next[3] = oType == OT_VENT && (useFeedback ? feedbackSync : active);
    outs_next[4] = oType == OT_EXTING &&
                   (useFeedback ? feedbackSync : active);
    outs_next[5] = oType == OT_ROUTING &&
                   (useFeedback ? feedbackSync : active);
    outs_next[6] = oType == OT_ALARM &&
                   (faultSync ? blinkPhase : alarmDis);
    outs_next[7] = oType == OT_ROUTING &&
                   (faultSync ? blinkPhase : routDis);
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) outs_reg <= 8'h00;
    else outs_reg <= outs_next;
  end
  assign outDrive = outs_reg[0];
  assign supervisionOn = outs_reg[1];
  assign interlockView = outs_reg[2];
  assign ledVent = outs_reg[3];
  assign ledExting = outs_reg[4];
  assign ledRouting = outs_reg[5];
  assign ledAlarmFaultDis = outs_reg[6];
  assign ledRoutingFaultDis = outs_reg[7];

  // Read mux; unmapped addresses read zero
  wire [31:0] statWord = {16'h0000, outs_reg, 2'b00, faultSync, restartLow,
                          active, req, ctrlExpr, forcedOff};
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (hitCfg) rdata_next = {20'h0_0000, cfg_reg};
    else if (hitCmd) rdata_next = {25'h000_0000, cmd_reg};
    else if (hitStat) rdata_next = statWord;
    else if (hitPType) rdata_next = {29'h0000_0000, perType_reg[perIdx]};
    else if (hitPTime) rdata_next = perTime_reg[perIdx];
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) rdata_reg <= 32'h0000_0000;
    else if (regRd) rdata_reg <= rdata_next;
    else rdata_reg <= 32'h0000_0000;
  end
  assign regRdata = rdata_reg;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_neutral_no_led:
    assert property (oType == OT_NEUTRAL |=> !ledAlarmFaultDis &&
                     !ledRoutingFaultDis && !ledRouting)
    else $error("neutral output lit an indicator");
  a_type_disable:
    assert property (collOff |=> !active)
    else $error("collectively disabled output still active");
  a_silence_off:
    assert property (oType == OT_ALARM && silenceSync |=> !active)
    else $error("silenced alarm device still active");
  a_polarity_drive:
    assert property (!restartLow && $stable(polHigh) |=>
                     outDrive == ($past(polHigh) ^ $past(active)))
    else $error("drive does not follow polarity and activity");
  a_no_sup_high:
    assert property (polHigh |=> !supervisionOn)
    else $error("idle-high output supervised");
  a_restart_low:
    assert property (restartLow |=> !outDrive)
    else $error("output not low during restart");
  a_interlock_view:
    assert property (oType == OT_INTERLOCK && active |=> interlockView)
    else $error("interlocking activity not reported");
  a_pulse_once:
    assert property (gs_reg == GS_DONE && req |=> gs_reg == GS_DONE)
    else $error("pulse repeated within one request");
  a_steady_follows:
    assert property (pType == PT_STEADY && req && gs_reg == GS_IDLE
                     |=> gs_reg == GS_ON)
    else $error("steady output did not activate");
  a_delay_wait:
    assert property (gs_reg == GS_DELAY && !timeUp |=> !active)
    else $error("activation before delay elapsed");
  a_clamp_time:
    assert property (limited |-> tPlen <= LIMIT_TICKS && tPoff <= LIMIT_TICKS)
    else $error("limited unit time above bound");
  a_fixed_blink:
    assert property (fixedBlink && isInterm |-> tPlen == FIXED_BLINK_TICKS)
    else $error("fixed-blink unit not at 0.8 s");
  a_interlock_type:
    assert property (oType == OT_INTERLOCK |-> pType == PT_STEADY ||
                     pType == PT_STEADY_DA)
    else $error("interlocking output used forbidden period");

  a_vent_led:
    assert property (oType == OT_VENT && !useFeedback && active |=> ledVent)
    else $error("active ventilation output not indicated");

  a_exting_led:
    assert property (oType == OT_EXTING && !useFeedback && active |=> ledExting)
    else $error("active extinguishing output not indicated");

  a_alarm_dis_led:
    assert property (alarmDis && !faultSync |=> ledAlarmFaultDis)
    else $error("alarm device disablement not indicated");

  c_interm_cycle: cover property (gs_reg == GS_ON ##1 gs_reg == GS_OFF);
  c_hold_release: cover property (gs_reg == GS_HOLD ##1 gs_reg == GS_IDLE);
  c_pulse_done: cover property (gs_reg == GS_DONE);
  c_delay_on: cover property (gs_reg == GS_DELAY ##1 gs_reg == GS_ON);
endmodule
`default_nettype wire

// ### bench/tb.sv
// Purpose: Self-checking bench for one programmable output controller
// Assumes: 25 MHz clock, TICK_LEN 10 and RESTART_LEN 20 to keep runs short
// Notes: N ticks last (N-1)*10+2 to N*10+1 cycles, as the tick runs free
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pos_pkg::*;
  logic clk, arst_n, regWr, regRd, ctrlExpr, silencePin, feedbackPin;
  logic outFaultPin, outDrive, supervisionOn, interlockView, ledVent;
  logic ledExting, ledRouting, ledAlarmFaultDis, ledRoutingFaultDis;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata, rv;
  logic [4:0] ex;
  int failures = 0;
  int n_checks = 0;
  int w, n, cnt;

  pos_output #(.TICK_LEN(10), .RESTART_LEN(20)) dut (.clk(clk),
    .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .ctrlExpr(ctrlExpr),
    .silencePin(silencePin), .feedbackPin(feedbackPin),
    .outFaultPin(outFaultPin), .outDrive(outDrive),
    .supervisionOn(supervisionOn), .interlockView(interlockView),
    .ledVent(ledVent), .ledExting(ledExting), .ledRouting(ledRouting),
    .ledAlarmFaultDis(ledAlarmFaultDis),
    .ledRoutingFaultDis(ledRoutingFaultDis));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic close_out;
    if (failures == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkIn(input int got, input int lo, input int hi);
    n_checks++;
    if (got < lo || got > hi) begin
      failures++;
      $display("ERROR at %0t: got %h expected %h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic hold = 1'b0);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    // A held strobe lets the next write follow with no gap
    if (!hold) regWr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(posedge clk);
    d = regRdata;
  endtask

  function automatic logic [31:0] cfgw(input logic [2:0] t, input logic pol,
      input logic sup, input logic [3:0] sel, input logic [1:0] un,
      input logic fb);
    cfgw = 32'h0000_0000;
    cfgw[2:0] = t;
    cfgw[3] = pol;
    cfgw[4] = sup;
    cfgw[8:5] = sel;
    cfgw[10:9] = un;
    cfgw[11] = fb;
  endfunction

  // Time to first drive (w) and length of the high run (n)
  task automatic runHigh(input int lim);
    w = 0;
    n = 0;
    while (outDrive !== 1'b1 && w < lim) begin
      @(posedge clk);
      w++;
    end
    while (outDrive === 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask

  // Idle the request, load user period 1, select period sel, request and measure
  task automatic go(input logic [2:0] pt, input logic [31:0] tm,
      input logic [1:0] un, input logic [2:0] ot, input logic [3:0] sel);
    ctrlExpr <= 1'b0;
    tick(80);
    wr(8'h40, {29'h0, pt}, 1'b1);
    wr(8'h44, tm, 1'b1);
    wr(OFS_CFG, cfgw(ot, 1'b0, 1'b1, sel, un, 1'b0));
    ctrlExpr <= 1'b1;
    runHigh(700);
  endtask

  initial begin
    tick(30000);
    failures++;
    close_out();
  end

  initial begin
    arst_n = 1'b0;
    {regWr, regRd, ctrlExpr, silencePin, feedbackPin, outFaultPin} = '0;
    regAddr = 8'h00;
    regWdata = 32'h0000_0000;
    tick(10);
    arst_n <= 1'b1;
    tick(2);
    chk(supervisionOn, 1'b1);
    rd(OFS_CFG, rv);
    chk(rv, 32'h0000_0010);
    wr(OFS_CFG, cfgw(3'h0, 1'b1, 1'b1, 4'h0, 2'h0, 1'b0));
    tick(2);
    chk(outDrive, 1'b0);
    chk(supervisionOn, 1'b0);
    tick(30);
    chk(outDrive, 1'b1);
    ctrlExpr <= 1'b1;
    tick(4);
    chk(outDrive, 1'b0);
    ctrlExpr <= 1'b0;
    tick(4);
    chk(outDrive, 1'b1);
    rd(8'h20, rv);
    chk(rv, 32'h0000_0000);
    rd(OFS_CFG, rv);
    chk(rv, 32'h0000_0018);
    tick(1);
    chk(regRdata, 32'h0000_0000);
    wr(OFS_CFG, cfgw(3'h0, 1'b0, 1'b0, 4'h0, 2'h0, 1'b0));
    tick(2);
    chk(supervisionOn, 1'b0);
    // Every output type, first disabled by its own command bit (neutral gets four more bits and stays on), then free
    for (int d = 1; d >= 0; d--) begin
      for (int t = 0; t < 7; t++) begin
        wr(OFS_CMD, d == 0 ? 32'h0 : (t == 5 ? 32'h67 : 32'h1 << t), 1'b1);
        wr(OFS_CFG, cfgw(t[2:0], 1'b0, 1'b1, 4'h0, 2'h0, 1'b0));
        ctrlExpr <= 1'b1;
        tick(5);
        ex = {t == 6, t == 4, t == 2, t == 1, 1'b1};
        if (d == 1) ex = (t == 5) ? 5'h01 : 5'h00;
        rv = {27'h0, interlockView, ledRouting, ledExting, ledVent,
              outDrive};
        chk(rv, {27'h0, ex});
        chk(ledAlarmFaultDis, d == 1 && t == 3);
        chk(ledRoutingFaultDis, d == 1 && t == 4);
        ctrlExpr <= 1'b0;
        tick(4);
      end
    end
    wr(OFS_CFG, cfgw(3'h3, 1'b0, 1'b1, 4'h0, 2'h0, 1'b0));
    silencePin <= 1'b1;
    ctrlExpr <= 1'b1;
    tick(6);
    chk(outDrive, 1'b0);
    silencePin <= 1'b0;
    tick(6);
    chk(outDrive, 1'b1);
    ctrlExpr <= 1'b0;
    outFaultPin <= 1'b1;
    tick(4);
    cnt = 0;
    repeat (320) begin
      @(posedge clk);
      if (ledAlarmFaultDis === 1'b1) cnt++;
    end
    chkIn(cnt, 120, 200);
    outFaultPin <= 1'b0;
    feedbackPin <= 1'b1;
    wr(OFS_CFG, cfgw(3'h1, 1'b0, 1'b1, 4'h0, 2'h0, 1'b1));
    tick(5);
    chk(ledVent, 1'b1);
    wr(OFS_CFG, cfgw(3'h2, 1'b0, 1'b1, 4'h0, 2'h0, 1'b1));
    tick(5);
    chk(ledExting, 1'b1);
    feedbackPin <= 1'b0;
    go(PT_STEADY, 32'h0, 2'h0, 3'h0, 4'h1);
    chkIn(n, 72, 81);
    go(PT_STEADY_DA, 32'h0000_0005, 2'h0, 3'h0, 4'h2);
    chkIn(w, 45, 54);
    chkIn(n, 700, 700);
    go(PT_PULSE, 32'h0000_0300, 2'h0, 3'h0, 4'h2);
    chkIn(n, 22, 31);
    tick(50);
    chk(outDrive, 1'b0);
    go(PT_PULSE_DA, 32'h0000_0302, 2'h0, 3'h0, 4'h2);
    chkIn(w, 15, 24);
    chkIn(n, 22, 31);
    go(PT_INTERM, 32'h0003_0200, 2'h0, 3'h0, 4'h2);
    chkIn(n, 12, 21);
    runHigh(200);
    chkIn(w, 22, 31);
    go(PT_INTERM_DA, 32'h0003_0204, 2'h0, 3'h0, 4'h2);
    chkIn(w, 35, 44);
    go(PT_STEADY_DD, 32'h0500_0000, 2'h0, 3'h0, 4'h2);
    ctrlExpr <= 1'b0;
    runHigh(200);
    chkIn(n, 45, 54);
    go(PT_INTERM, 32'h0003_0200, 2'h1, 3'h0, 4'h2);
    chkIn(n, 72, 81);
    go(PT_PULSE, 32'h0000_FF00, 2'h2, 3'h0, 4'h2);
    chkIn(n, 552, 561);
    go(PT_STEADY_DD, 32'h0500_0000, 2'h0, 3'h6, 4'h2);
    ctrlExpr <= 1'b0;
    tick(5);
    chk(outDrive, 1'b0);
    close_out();
  end
endmodule
`default_nettype wire
